/* File: common/tmf_pkg.sv */
package tmf_pkg;

	// ----------------------------------------------------------------
	// Timing.
	// ----------------------------------------------------------------
	localparam int CLK_MHZ = 200;
	localparam int MEAS_US = 9600;
	localparam int MEAS_CYCLES = MEAS_US * CLK_MHZ;
	localparam int SAMPLES = 16;
	localparam int SAMPLE_CYCLES = MEAS_CYCLES / (2 * SAMPLES);

	// ----------------------------------------------------------------
	// Reset values and codes.
	// ----------------------------------------------------------------
	localparam logic [7:0] FAN_CODE_RESET = 8'h00;
	localparam logic [7:0] FAN_CODE_FULL = 8'hFF;
	localparam logic [7:0] TEMP_RESET = 8'h00;
	localparam logic [7:0] TEMP_MIN = 8'h80;
	localparam logic [7:0] TEMP_MAX = 8'h7F;
	localparam int CFG_DIODE2_BIT = 7;

	typedef enum logic [3:0] {
		TMF_ST_LOCAL = 4'b0001,
		TMF_ST_REM1 = 4'b0010,
		TMF_ST_REM2 = 4'b0100,
		TMF_ST_TEST = 4'b1000
	} tmf_state_t;

endpackage : tmf_pkg

/* File: rtl/tmf_sync.sv */
`timescale 1ns/1ps
module tmf_sync #(
	parameter int WIDTH = 1
) (
	// Clock and reset.
	input wire logic clock_in,
	input wire logic rst_in,
	// Asynchronous level and its filtered copy.
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] stage1;
	logic [WIDTH-1:0] stage2;
	logic [WIDTH-1:0] stage3;
	wire [WIDTH-1:0] agree = ~(stage2 ^ stage3);

	// The stages keep sampling during reset so that straps and idle pin levels are settled at release.
	always_ff @(posedge clock_in) begin
		stage1 <= async_in;
		stage2 <= stage1;
		stage3 <= stage2;
	end

	// Reset loads the settled pin level, so no false pin change follows reset.
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			sync_out <= stage3;
		end else begin
			sync_out <= (agree & stage3) | (~agree & sync_out);
		end
	end
endmodule : tmf_sync

/* File: rtl/tmf_measure.sv */
`timescale 1ns/1ps
module tmf_measure
	import tmf_pkg::*;
#(
	parameter int SAMPLE_CYC = SAMPLE_CYCLES,
	parameter int NSAMP = SAMPLES
) (
	// Clock and reset.
	input wire logic clock_in,
	input wire logic rst_in,
	// Configuration.
	input wire logic diode2_enable_in,
	input wire logic [7:0] fan_code_in,
	input wire logic fan_enable_in,
	// Converter results, two's complement.
	input wire logic [7:0] local_adc_in,
	input wire logic [7:0] remote_adc_in,
	// Shared pins and strap.
	input wire logic thermal_alarm_pin_in,
	input wire logic general_input_pin_in,
	input wire logic nand_test_strap_in,
	// Excitation control.
	output logic remote_select_out,
	output logic high_current_out,
	// Results.
	output logic [7:0] local_temp_out,
	output logic [7:0] remote1_temp_out,
	output logic [7:0] remote2_temp_out,
	output logic result_valid_out,
	// Fan drive, general input and test mode.
	output logic [7:0] fan_speed_dac_out,
	output logic fan_gate_out,
	output logic general_input_out,
	output logic nand_test_mode_out
);
	localparam int CW = $clog2(SAMPLE_CYC + 1);
	localparam int NW = $clog2(NSAMP);
	localparam int SW = 8 + NW + 1;

	tmf_state_t state;
	tmf_state_t next_state;
	logic [CW-1:0] tick;
	logic [NW-1:0] count;
	logic phase;
	logic [7:0] low_sample;
	logic signed [SW-1:0] acc;
	logic strap_done;
	logic [2:0] pins_sync;

	tmf_sync #(
		.WIDTH(3)
	) u_sync (
		.clock_in(clock_in),
		.rst_in(rst_in),
		.async_in({thermal_alarm_pin_in, general_input_pin_in, nand_test_strap_in}),
		.sync_out(pins_sync)
	);

	// ----------------------------------------------------------------
	// Decoding.
	// ----------------------------------------------------------------
	wire tick_end = (tick == CW'(SAMPLE_CYC - 1));
	wire last = (count == NW'(NSAMP - 1));
	wire alarm_active = ~diode2_enable_in & ~pins_sync[2];
	wire remote_state = (state == TMF_ST_REM1) | (state == TMF_ST_REM2);
	wire [7:0] diff = remote_adc_in - low_sample;
	wire signed [SW-1:0] acc_next = acc + SW'(signed'(diff));
	wire signed [SW-1:0] acc_local = acc + SW'(signed'(local_adc_in));
	wire [7:0] average = acc_next[NW +: 8];
	wire [7:0] average_local = acc_local[NW +: 8];
	wire step_done = tick_end & (remote_state ? phase : 1'b1);
	wire conv_done = step_done & last;

	always_comb begin
		next_state = state;
		unique case (state)
			TMF_ST_LOCAL: next_state = TMF_ST_REM1;
			TMF_ST_REM1: next_state = diode2_enable_in ? TMF_ST_REM2 : TMF_ST_LOCAL;
			TMF_ST_REM2: next_state = TMF_ST_LOCAL;
			TMF_ST_TEST: next_state = TMF_ST_TEST;
		endcase
	end

	// ----------------------------------------------------------------
	// Strap capture and sequencing.
	// ----------------------------------------------------------------
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			strap_done <= 1'b0;
			nand_test_mode_out <= 1'b0;
			state <= TMF_ST_LOCAL;
		end else begin
			strap_done <= 1'b1;
			if (!strap_done && pins_sync[0]) begin
				nand_test_mode_out <= 1'b1;
				state <= TMF_ST_TEST;
			end else if (conv_done) begin
				state <= next_state;
			end
		end
	end

	always_ff @(posedge clock_in) begin
		if (rst_in || state == TMF_ST_TEST) begin
			tick <= '0;
			count <= '0;
			phase <= 1'b0;
			acc <= '0;
			low_sample <= TEMP_RESET;
		end else begin
			tick <= tick_end ? '0 : tick + CW'(1);
			if (tick_end && remote_state && !phase) begin
				low_sample <= remote_adc_in;
				phase <= 1'b1;
			end else if (step_done) begin
				phase <= 1'b0;
				count <= last ? '0 : count + NW'(1);
				acc <= last ? '0 : (remote_state ? acc_next : acc_local);
			end
		end
	end

	// ----------------------------------------------------------------
	// Result registers.
	// ----------------------------------------------------------------
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			local_temp_out <= TEMP_RESET;
			remote1_temp_out <= TEMP_RESET;
			remote2_temp_out <= TEMP_RESET;
			result_valid_out <= 1'b0;
		end else begin
			result_valid_out <= conv_done;
			if (conv_done && state == TMF_ST_LOCAL) begin
				local_temp_out <= average_local;
			end
			if (conv_done && state == TMF_ST_REM1) begin
				remote1_temp_out <= average;
			end
			if (conv_done && state == TMF_ST_REM2) begin
				remote2_temp_out <= average;
			end
		end
	end

	// ----------------------------------------------------------------
	// Fan drive and pin outputs.
	// ----------------------------------------------------------------
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			fan_speed_dac_out <= FAN_CODE_RESET;
			fan_gate_out <= 1'b0;
			remote_select_out <= 1'b0;
			high_current_out <= 1'b0;
			general_input_out <= 1'b0;
		end else begin
			fan_speed_dac_out <= alarm_active ? FAN_CODE_FULL : fan_code_in;
			fan_gate_out <= fan_enable_in & ~alarm_active;
			remote_select_out <= (state == TMF_ST_REM2);
			high_current_out <= remote_state & phase;
			general_input_out <= diode2_enable_in ? 1'b0 : pins_sync[1];
		end
	end
endmodule : tmf_measure

/* File: testbench/tmf_measure_props.sv */
`timescale 1ns/1ps
// ----
// Checker.
// ----
module tmf_measure_props #(parameter int SAMPLE_CYC = 4) (
	input wire logic clock_in, rst_in, diode2_enable_in, fan_enable_in, thermal_alarm_pin_in,
	input wire logic [7:0] fan_code_in, local_temp_out, fan_speed_dac_out,
	input wire logic high_current_out, remote_select_out, result_valid_out, fan_gate_out,
	input wire logic general_input_out, nand_test_mode_out
);
	default clocking cb @(posedge clock_in); endclocking
	default disable iff (rst_in);
	property p_code; (thermal_alarm_pin_in && !nand_test_mode_out)[*7] |-> fan_speed_dac_out == $past(fan_code_in);
	endproperty
	a_code: assert property (p_code) else $error("fan code not passed");
	property p_forced; (!thermal_alarm_pin_in && !diode2_enable_in && !nand_test_mode_out)[*7]
		|-> fan_speed_dac_out == 8'hFF && !fan_gate_out; endproperty
	a_forced: assert property (p_forced) else $error("alarm not forcing fan");
	property p_gate; fan_gate_out |-> $past(fan_enable_in); endproperty
	a_gate: assert property (p_gate) else $error("fan gate without request");
	property p_valid; result_valid_out |=> !result_valid_out; endproperty
	a_valid: assert property (p_valid) else $error("valid too long");
	property p_half; $rose(high_current_out) |-> !$past(high_current_out, SAMPLE_CYC) ##SAMPLE_CYC !high_current_out;
	endproperty
	a_half: assert property (p_half) else $error("excitation half wrong");
	property p_rem2; $rose(remote_select_out) |-> diode2_enable_in; endproperty
	a_rem2: assert property (p_rem2) else $error("channel two not enabled");
	property p_gpi; diode2_enable_in |=> !general_input_out; endproperty
	a_gpi: assert property (p_gpi) else $error("general input while diode");
	property p_freeze; nand_test_mode_out |=> nand_test_mode_out && $stable(local_temp_out) && !result_valid_out;
	endproperty
	a_freeze: assert property (p_freeze) else $error("test mode not frozen");
	c_rem2: cover property ($fell(remote_select_out));
	c_alarm: cover property (fan_speed_dac_out == 8'hFF && !fan_gate_out);
	c_test: cover property ($rose(nand_test_mode_out));
endmodule : tmf_measure_props
bind tmf_measure tmf_measure_props #(.SAMPLE_CYC(SAMPLE_CYC)) props_u (.clock_in, .rst_in, .diode2_enable_in,
	.fan_enable_in, .thermal_alarm_pin_in, .fan_code_in, .local_temp_out, .fan_speed_dac_out, .high_current_out,
	.remote_select_out, .result_valid_out, .fan_gate_out, .general_input_out, .nand_test_mode_out);

/* File: testbench/tmf_diode_model.sv */
`timescale 1ns/1ps
// ----
// Sensors seen by the converter.
// ----
module tmf_diode_model (
	input wire logic high_current_in, remote_select_in,
	output logic [7:0] remote_adc_out, local_adc_out
);
	assign local_adc_out = 8'h19;
	assign remote_adc_out = high_current_in ? 8'h10 + (remote_select_in ? 8'h64 : 8'hE7) : 8'h10;
endmodule : tmf_diode_model

/* File: testbench/temp_measure_fan_dac_tb.sv */
`timescale 1ns/1ps
module temp_measure_fan_dac_tb import tmf_pkg::*; ;
	localparam int SC = 4;
	logic clock_in = 1'b0, rst_in = 1'b1, d2 = 1'b0, fen = 1'b0, alm = 1'b1, general_input_pin = 1'b0, strap = 1'b0;
	logic [7:0] code = 8'h00;
	wire logic [7:0] ladc, radc, lt, r1, r2, dac;
	wire logic sel, hc, vld, gate, gpo, ntm;
	int fails = 0, num_checks = 0, n;
	always #2.5 clock_in = ~clock_in;
	tmf_measure #(.SAMPLE_CYC(SC)) dut_u (.clock_in, .rst_in, .diode2_enable_in(d2), .fan_code_in(code),
		.fan_enable_in(fen), .local_adc_in(ladc), .remote_adc_in(radc), .thermal_alarm_pin_in(alm),
		.general_input_pin_in(general_input_pin), .nand_test_strap_in(strap), .remote_select_out(sel), .high_current_out(hc),
		.local_temp_out(lt), .remote1_temp_out(r1), .remote2_temp_out(r2), .result_valid_out(vld),
		.fan_speed_dac_out(dac), .fan_gate_out(gate), .general_input_out(gpo), .nand_test_mode_out(ntm));
	tmf_diode_model model_u (.high_current_in(hc), .remote_select_in(sel), .remote_adc_out(radc), .local_adc_out(ladc));
	task step(input int k); repeat (k) @(posedge clock_in); #1; endtask : step
	task check(input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp) begin
			fails++;
			$display("[ERR] %0t got %h expected %h", $time, seen, exp);
		end
	endtask : check
	task report_and_stop;
		if (fails == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : report_and_stop
	task do_reset(input logic s); strap = s; rst_in = 1'b1; step(5); rst_in = 1'b0; step(1); endtask : do_reset
	task t_reset; do_reset(1'b0); check(dac, FAN_CODE_RESET); check(ntm, 8'h00); endtask : t_reset
	task t_fan;
		code = 8'hA5; fen = 1'b1; step(2); check(dac, 8'hA5); check(gate, 8'h01);
		fen = 1'b0; step(2); check(gate, 8'h00); check(dac, 8'hA5);
	endtask : t_fan
	task t_alarm;
		fen = 1'b1; alm = 1'b0; step(8); check(dac, FAN_CODE_FULL); check(gate, 8'h00);
		code = 8'h3C; step(2); check(dac, FAN_CODE_FULL);
		alm = 1'b1; step(8); check(dac, 8'h3C); check(gate, 8'h01);
	endtask : t_alarm
	task t_gpi; general_input_pin = 1'b1; step(6); check(gpo, 8'h01); d2 = 1'b1; step(2); check(gpo, 8'h00); endtask : t_gpi
	task t_meas;
		n = 0;
		for (int i = 0; i < 1000 && sel !== 1'b1; i++) step(1);
		while (sel === 1'b1 && n < 1000) begin
			n++;
			step(1);
		end
		check(8'(n), 8'(2 * SAMPLES * SC));
		step(2);
		check(lt, 8'h19);
		check(r1, 8'hE7);
		check(r2, 8'h64);
		d2 = 1'b0; n = 0;
		repeat (700) begin
			step(1);
			if (sel === 1'b1) n++;
		end
		check(8'(n), 8'h00);
	endtask : t_meas
	task t_strap;
		do_reset(1'b1); step(1); check(ntm, 8'h01); n = 0;
		repeat (200) begin
			step(1);
			if (vld !== 1'b0) n++;
		end
		check(8'(n), 8'h00); check(lt, TEMP_RESET);
		do_reset(1'b0); step(1); check(ntm, 8'h00);
	endtask : t_strap
	initial begin
		t_reset; t_fan; t_alarm; t_gpi; t_meas; t_strap;
		report_and_stop;
	end
	initial begin
		#25000;
		fails++;
		report_and_stop;
	end
endmodule : temp_measure_fan_dac_tb
